// >>> ccp_pkg.sv
`default_nettype none
package ccp_pkg;
    // Command word layout
    localparam int CMD_BITS      = 16;
    localparam int REG_ADDR_W    = 7;
    localparam int REG_DATA_W    = 9;
    // Register addresses
    localparam logic [6:0] ADDR_SAMPLING = 7'h08;
    localparam logic [6:0] ADDR_ACTIVATE = 7'h09;
    // Field positions in sampling and activate registers
    localparam int SAMP_USB_BIT  = 0;
    localparam int SAMP_BASE_OVERSAMPLE_SEL_BIT = 1;
    localparam int SAMP_SR_LSB   = 2;
    localparam int ACTIVATE_BIT  = 0;
    // Reset values
    localparam logic [8:0] SAMPLING_RST = 9'h000;
    localparam logic       ACTIVATE_RST = 1'b0;
    // Two-wire slave address: 6-bit base plus pin bit
    localparam logic [5:0] SLAVE_BASE   = 6'h0d;
    // Master clock and oversampling
    localparam int MCLK_USB_HZ   = 12000000;
    localparam int OSR_BASE0     = 250;
    localparam int OSR_BASE1     = 272;
    // Frame and bit counts
    localparam logic [3:0] BYTE_LAST    = 4'h7;
    localparam logic [4:0] WORD_LAST    = 5'h0f;
    // Rate decode result: digital filter type
    typedef enum logic [1:0] {
        CCP_FILT0, CCP_FILT1, CCP_FILT2, CCP_FILT3
    } ccp_filt_t;
endpackage : ccp_pkg
`default_nettype wire

// >>> ccp_rate_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Maps oversample bit and rate code to converter dividers of the 12 MHz clock.
// Divider counts in master clock periods; zero means unsupported setting.
module ccp_rate_decode (
    // Setting
    input  wire logic             osrSel,
    input  wire logic [3:0]       rateCode,
    // Decode
    output logic [15:0]           adcDiv,
    output logic [15:0]           dacDiv,
    output ccp_pkg::ccp_filt_t    filtType,
    output logic                  rateValid
);
    localparam logic [15:0] D250 = 16'(ccp_pkg::OSR_BASE0);
    localparam logic [15:0] D272 = 16'(ccp_pkg::OSR_BASE1);

    always_comb begin
        adcDiv    = 16'h0000;
        dacDiv    = 16'h0000;
        filtType  = ccp_pkg::CCP_FILT0;
        rateValid = 1'b1;
        unique case ({osrSel, rateCode})
            5'h00: begin adcDiv = D250; dacDiv = D250; end
            5'h01: begin adcDiv = D250; dacDiv = D250 * 16'h0006; end
            5'h02: begin adcDiv = D250 * 16'h0006; dacDiv = D250; end
            5'h03: begin adcDiv = D250 * 16'h0006; dacDiv = D250 * 16'h0006; end
            5'h06: begin
                adcDiv = 16'h0177;
                dacDiv = 16'h0177;
            end
            5'h07: begin
                adcDiv   = D250 >> 1;
                dacDiv   = D250 >> 1;
                filtType = ccp_pkg::CCP_FILT3;
            end
            5'h18: begin adcDiv = D272; dacDiv = D272; filtType = ccp_pkg::CCP_FILT1; end
            5'h19: begin
                adcDiv = D272; dacDiv = 16'h05d8; filtType = ccp_pkg::CCP_FILT1;
            end
            5'h1a: begin
                adcDiv = 16'h05d8; dacDiv = D272; filtType = ccp_pkg::CCP_FILT1;
            end
            5'h1b: begin
                adcDiv = 16'h05d8; dacDiv = 16'h05d8; filtType = ccp_pkg::CCP_FILT1;
            end
            5'h1f: begin
                adcDiv = D272 >> 1; dacDiv = D272 >> 1; filtType = ccp_pkg::CCP_FILT2;
            end
            default: rateValid = 1'b0;  // Host must avoid these
        endcase
    end
endmodule : ccp_rate_decode
`default_nettype wire

// >>> ccp_control_port.sv
`timescale 1ns/1ps
`default_nettype none
module ccp_control_port (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             clkEn,
    // Control link pins
    input  wire logic             ctrl_link_select_pin,
    input  wire logic             ctrl_serial_clock,
    input  wire logic             ctrl_latch_select,
    input  wire logic             ctrl_serial_data_in,
    output logic                  ctrl_serial_data_out,
    output logic                  ctrl_serial_data_oe,
    // Audio port gating
    output logic                  audioPortEn,
    output logic                  audioPortPullDown,
    // Sampling decode
    output logic                  usbMode,
    output logic                  base_oversample_sel,
    output logic [3:0]            rate_select_code,
    output logic [15:0]           adcDivider,
    output logic [15:0]           dacDivider,
    output ccp_pkg::ccp_filt_t    filterType,
    output logic                  rateSupported,
    // Write strobe for the wider register map
    output logic                  regWrStb,
    output logic [6:0]            regWrAddr,
    output logic [8:0]            regWrData
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] sync1_r, sync1_nxt;
    logic [3:0] sync2_r, sync2_nxt;
    logic [3:0] prev_r,  prev_nxt;
    logic       sclS, sdaS, csbS, modeS;
    logic       sclRise, sclFall, csbRise;

    always_comb begin
        sync1_nxt = {ctrl_link_select_pin, ctrl_latch_select, ctrl_serial_data_in,
                     ctrl_serial_clock};
        sync2_nxt = sync1_r;
        prev_nxt  = sync2_r;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            // Idle bus levels, so no false start follows reset
            sync1_r <= 4'h3;
            sync2_r <= 4'h3;
            prev_r  <= 4'h3;
        end else if (clkEn) begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r  <= prev_nxt;
        end
    end

    assign sclS    = sync2_r[0];
    assign sdaS    = sync2_r[1];
    assign csbS    = sync2_r[2];
    assign modeS   = sync2_r[3];
    assign sclRise = sclS & ~prev_r[0];
    assign sclFall = ~sclS & prev_r[0];
    assign csbRise = csbS & ~prev_r[2];

    // Start and stop seen only with clock steady high
    logic startCond, stopCond;
    assign startCond = ~modeS & sclS & prev_r[0] & prev_r[1] & ~sdaS;
    assign stopCond  = ~modeS & sclS & prev_r[0] & ~prev_r[1] & sdaS;

    // ------------------------------------------------------------
    // Link engine
    // ------------------------------------------------------------
    typedef enum {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_HI, ST_HI_ACK, ST_LO, ST_LO_ACK, ST_WAIT_STOP
    } ccp_state_t;

    ccp_state_t state_r, state_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic [3:0]  bitCnt_r, bitCnt_nxt;
    logic [4:0]  spiCnt_r, spiCnt_nxt;
    logic        ackDrv_r, ackDrv_nxt;
    logic        ackSeen_r, ackSeen_nxt;
    logic        cmdDone;
    logic [6:0]  myAddr;

    assign myAddr = {ccp_pkg::SLAVE_BASE, csbS};

    always_comb begin
        state_nxt   = state_r;
        shift_nxt   = shift_r;
        bitCnt_nxt  = bitCnt_r;
        spiCnt_nxt  = spiCnt_r;
        ackDrv_nxt  = ackDrv_r;
        ackSeen_nxt = ackSeen_r;
        cmdDone     = 1'b0;
        if (modeS) begin
            // Three-wire: shift on clock, capture only on latch edge
            state_nxt  = ST_IDLE;
            ackDrv_nxt = 1'b0;
            if (sclRise) begin
                shift_nxt = {shift_r[14:0], sdaS};
                if (spiCnt_r != 5'h1f) spiCnt_nxt = spiCnt_r + 5'h01;
            end
            if (csbRise) begin
                cmdDone    = (spiCnt_r > ccp_pkg::WORD_LAST);
                spiCnt_nxt = 5'h00;
            end
        end else if (startCond) begin
            // Any start, in or out of sequence, restarts addressing
            state_nxt  = ST_ADDR;
            bitCnt_nxt = 4'h0;
            ackDrv_nxt = 1'b0;
        end else if (stopCond) begin
            state_nxt  = ST_IDLE;
            ackDrv_nxt = 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE, ST_WAIT_STOP: ackDrv_nxt = 1'b0;
                ST_ADDR, ST_HI, ST_LO: if (sclRise) begin
                    shift_nxt  = {shift_r[14:0], sdaS};
                    bitCnt_nxt = bitCnt_r + 4'h1;
                end else if (sclFall && bitCnt_r == ccp_pkg::BYTE_LAST + 4'h1) begin
                    bitCnt_nxt  = 4'h0;
                    ackSeen_nxt = 1'b0;
                    if (state_r == ST_ADDR) begin
                        if (shift_r[7:1] == myAddr && !shift_r[0]) begin
                            state_nxt  = ST_ADDR_ACK;
                            ackDrv_nxt = 1'b1;
                        end else begin
                            state_nxt = ST_IDLE;
                        end
                    end else begin
                        state_nxt  = (state_r == ST_HI) ? ST_HI_ACK : ST_LO_ACK;
                        ackDrv_nxt = 1'b1;
                    end
                end
                ST_ADDR_ACK, ST_HI_ACK, ST_LO_ACK: if (sclRise) begin
                    ackSeen_nxt = 1'b1;
                end else if (sclFall && ackSeen_r) begin
                    ackDrv_nxt = 1'b0;
                    unique case (state_r)
                        ST_ADDR_ACK: state_nxt = ST_HI;
                        ST_HI_ACK:   state_nxt = ST_LO;
                        default: begin
                            state_nxt = ST_WAIT_STOP;
                            cmdDone   = 1'b1;
                        end
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r   <= ST_IDLE;
            shift_r   <= 16'h0000;
            bitCnt_r  <= 4'h0;
            spiCnt_r  <= 5'h00;
            ackDrv_r  <= 1'b0;
            ackSeen_r <= 1'b0;
        end else if (clkEn) begin
            state_r   <= state_nxt;
            shift_r   <= shift_nxt;
            bitCnt_r  <= bitCnt_nxt;
            spiCnt_r  <= spiCnt_nxt;
            ackDrv_r  <= ackDrv_nxt;
            ackSeen_r <= ackSeen_nxt;
        end
    end

    // Open drain: only ever pull data low; clock is never driven
    assign ctrl_serial_data_out = 1'b0;
    assign ctrl_serial_data_oe  = ackDrv_r;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [8:0] sampling_r, sampling_nxt;
    logic       activate_r, activate_nxt;
    logic       wrStb_r, wrStb_nxt;
    logic [6:0] wrAddr_r, wrAddr_nxt;
    logic [8:0] wrData_r, wrData_nxt;
    logic [6:0] cmdAddr;
    logic [8:0] cmdData;

    assign cmdAddr = shift_r[15:9];
    assign cmdData = shift_r[8:0];

    always_comb begin
        sampling_nxt = sampling_r;
        activate_nxt = activate_r;
        wrStb_nxt    = cmdDone;
        wrAddr_nxt   = wrAddr_r;
        wrData_nxt   = wrData_r;
        if (cmdDone) begin
            wrAddr_nxt = cmdAddr;
            wrData_nxt = cmdData;
            if (cmdAddr == ccp_pkg::ADDR_SAMPLING) sampling_nxt = cmdData;
            if (cmdAddr == ccp_pkg::ADDR_ACTIVATE)
                activate_nxt = cmdData[ccp_pkg::ACTIVATE_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sampling_r <= ccp_pkg::SAMPLING_RST;
            activate_r <= ccp_pkg::ACTIVATE_RST;
            wrStb_r    <= 1'b0;
            wrAddr_r   <= 7'h00;
            wrData_r   <= 9'h000;
        end else if (clkEn) begin
            sampling_r <= sampling_nxt;
            activate_r <= activate_nxt;
            wrStb_r    <= wrStb_nxt;
            wrAddr_r   <= wrAddr_nxt;
            wrData_r   <= wrData_nxt;
        end
    end

    // ------------------------------------------------------------
    // Rate decode, registered outputs
    // ------------------------------------------------------------
    logic [15:0]        adcDivC, dacDivC;
    ccp_pkg::ccp_filt_t filtC;
    logic               validC;
    logic [15:0]        adcDiv_r, adcDiv_nxt;
    logic [15:0]        dacDiv_r, dacDiv_nxt;
    ccp_pkg::ccp_filt_t filt_r, filt_nxt;
    logic               valid_r, valid_nxt;

    ccp_rate_decode ccp_rate_decode_i (
        .osrSel    (sampling_r[ccp_pkg::SAMP_BASE_OVERSAMPLE_SEL_BIT]),
        .rateCode  (sampling_r[ccp_pkg::SAMP_SR_LSB +: 4]),
        .adcDiv    (adcDivC),
        .dacDiv    (dacDivC),
        .filtType  (filtC),
        .rateValid (validC)
    );

    // Registered so outputs never ripple through the decode
    always_comb begin
        adcDiv_nxt = adcDivC;
        dacDiv_nxt = dacDivC;
        filt_nxt   = filtC;
        valid_nxt  = validC;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            adcDiv_r <= 16'h0000;
            dacDiv_r <= 16'h0000;
            filt_r   <= ccp_pkg::CCP_FILT0;
            valid_r  <= 1'b0;
        end else if (clkEn) begin
            adcDiv_r <= adcDiv_nxt;
            dacDiv_r <= dacDiv_nxt;
            filt_r   <= filt_nxt;
            valid_r  <= valid_nxt;
        end
    end

    assign usbMode             = sampling_r[ccp_pkg::SAMP_USB_BIT];
    assign base_oversample_sel = sampling_r[ccp_pkg::SAMP_BASE_OVERSAMPLE_SEL_BIT];
    assign rate_select_code    = sampling_r[ccp_pkg::SAMP_SR_LSB +: 4];
    assign audioPortEn         = activate_r;
    assign audioPortPullDown   = ~activate_r;
    assign regWrStb            = wrStb_r;
    assign regWrAddr           = wrAddr_r;
    assign regWrData           = wrData_r;
    assign adcDivider          = adcDiv_r;
    assign dacDivider          = dacDiv_r;
    assign filterType          = filt_r;
    assign rateSupported       = valid_r;
endmodule : ccp_control_port
`default_nettype wire

// >>> ccp_control_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Port checker
// ------------------------------
module ccp_control_port_checker (
    // Clock and pins
    input wire logic               ref_clk,
    input wire logic               reset,
    input wire logic               ctrl_link_select_pin,
    input wire logic               ctrl_serial_clock,
    input wire logic               ctrl_serial_data_oe,
    // Decoded state
    input wire logic               audioPortEn,
    input wire logic               audioPortPullDown,
    input wire logic               usbMode,
    input wire logic               base_oversample_sel,
    input wire logic [3:0]         rate_select_code,
    input wire logic [15:0]        adcDivider,
    input wire logic [15:0]        dacDivider,
    input wire ccp_pkg::ccp_filt_t filterType,
    input wire logic               rateSupported,
    // Write strobe
    input wire logic               regWrStb,
    input wire logic [6:0]         regWrAddr,
    input wire logic [8:0]         regWrData
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_pulldown_inverse: assert property (
        audioPortPullDown == !audioPortEn) else $error("pull-down does not mirror enable");
    a_strobe_single: assert property (
        regWrStb |=> !regWrStb && $stable({regWrAddr, regWrData}))
        else $error("write strobe not a single held pulse");
    a_activate_update: assert property (
        regWrStb && regWrAddr == ccp_pkg::ADDR_ACTIVATE |-> ##[0:2] audioPortEn == regWrData[0])
        else $error("activate bit not taken from write");
    a_sampling_fields: assert property (
        regWrStb && regWrAddr == ccp_pkg::ADDR_SAMPLING |-> ##[0:2]
        {rate_select_code, base_oversample_sel, usbMode} == regWrData[5:0])
        else $error("sampling fields not taken from write");
    a_enable_cause: assert property (
        $changed(audioPortEn) |-> regWrStb || $past(regWrStb) || $past(regWrStb, 2))
        else $error("enable changed without a write");
    a_three_wire_quiet: assert property (
        ctrl_link_select_pin [*8] |-> !ctrl_serial_data_oe)
        else $error("acknowledge driven in three-wire mode");
    a_ack_clock_low: assert property (
        $changed(ctrl_serial_data_oe) |-> !ctrl_serial_clock)
        else $error("acknowledge changed while clock high");
    a_filter3_divider: assert property (
        rateSupported && filterType == ccp_pkg::CCP_FILT3 |->
        adcDivider == 16'h007d && dacDivider == 16'h007d) else $error("filter 3 divider wrong");
    a_filter2_divider: assert property (
        rateSupported && filterType == ccp_pkg::CCP_FILT2 |->
        adcDivider == 16'h0088 && dacDivider == 16'h0088) else $error("filter 2 divider wrong");

    c_ack: cover property ($rose(ctrl_serial_data_oe));
    c_activate: cover property (regWrStb && regWrAddr == ccp_pkg::ADDR_ACTIVATE);
    c_bad_rate: cover property (regWrStb ##3 !rateSupported);
endmodule : ccp_control_port_checker

bind ccp_control_port ccp_control_port_checker ccp_control_port_checker_i (
    .ref_clk, .reset, .ctrl_link_select_pin, .ctrl_serial_clock, .ctrl_serial_data_oe,
    .audioPortEn, .audioPortPullDown, .usbMode, .base_oversample_sel, .rate_select_code,
    .adcDivider, .dacDivider, .filterType, .rateSupported, .regWrStb, .regWrAddr, .regWrData);
`default_nettype wire

// >>> ccp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Control-bus master model
// ------------------------------
module ccp_host_model (
    // Bench clock and resolved wire
    input wire logic clk,
    input wire logic sdaWire,
    // Driven pins
    output var logic scl,
    output var logic sdaRel,
    output var logic latch
);
    initial begin
        scl = 1'b1;
        sdaRel = 1'b1;
        latch = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    task automatic start();
        scl = 1'b1;
        wt(8);
        sdaRel = 1'b0;
        wt(8);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        wt(4);
        sdaRel = 1'b0;
        wt(4);
        scl = 1'b1;
        wt(8);
        sdaRel = 1'b1;
        wt(8);
    endtask : stop
    // Ninth pulse releases the wire so the pull-up shows a missing ack
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic [8:0] s;
        s = {b, 1'b1};
        for (int i = 0; i < 9; i++) begin
            wt(4);
            sdaRel = s[8];
            s = s << 1;
            wt(4);
            scl = 1'b1;
            wt(4);
            ack = sdaWire;
            wt(4);
            scl = 1'b0;
        end
    endtask : sendByte
    task automatic spi(input logic [15:0] w, input int n);
        scl = 1'b0;
        wt(8);
        for (int i = n - 1; i >= 0; i--) begin
            sdaRel = w[i];
            wt(8);
            scl = 1'b1;
            wt(8);
            scl = 1'b0;
        end
        wt(8);
        latch = 1'b1;
        wt(8);
        latch = 1'b0;
        sdaRel = ~w[0];
        wt(8);
    endtask : spi
endmodule : ccp_host_model
`default_nettype wire

// >>> codec_control_port_test.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Bench top
// ------------------------------
module codec_control_port_test;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic clkEn = 1'b1;
    logic selPin = 1'b0;
    wire logic sclPin, sdaRel, latchPin, sdaWire;
    logic dOut, dOe, audioPortEn, audioPortPullDown, usbMode, base_oversample_sel;
    logic rateSupported, regWrStb, k;
    logic [3:0] rate_select_code;
    logic [15:0] adcDivider, dacDivider;
    ccp_pkg::ccp_filt_t filterType;
    logic [6:0] regWrAddr;
    logic [8:0] regWrData;
    logic [4:0] r;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [15:0] expQ[$];
    // Supported settings as {code, oversample}; two extra decodes left out
    logic [4:0] rc[9] = '{5'h00, 5'h04, 5'h06, 5'h0c, 5'h0e, 5'h11, 5'h15, 5'h17, 5'h1f};
    int adcX[9] = '{250, 1500, 1500, 375, 125, 272, 1496, 1496, 136};
    int dacX[9] = '{250, 250, 1500, 375, 125, 272, 272, 1496, 136};
    int ftX[9] = '{0, 0, 0, 0, 3, 1, 1, 1, 2};
    localparam logic [15:0] ACT1 = {ccp_pkg::ADDR_ACTIVATE, 9'h001};
    localparam logic [15:0] ACT0 = {ccp_pkg::ADDR_ACTIVATE, 9'h000};

    assign sdaWire = sdaRel & (dOe ? dOut : 1'b1);
    always #25 ref_clk = ~ref_clk;

    ccp_control_port ccp_control_port_i (.ref_clk, .reset, .clkEn,
        .ctrl_link_select_pin(selPin), .ctrl_serial_clock(sclPin), .ctrl_latch_select(latchPin),
        .ctrl_serial_data_in(sdaWire), .ctrl_serial_data_out(dOut), .ctrl_serial_data_oe(dOe),
        .audioPortEn, .audioPortPullDown, .usbMode, .base_oversample_sel, .rate_select_code,
        .adcDivider, .dacDivider, .filterType, .rateSupported, .regWrStb, .regWrAddr, .regWrData);
    ccp_host_model ccp_host_model_i (.clk(ref_clk), .sdaWire, .scl(sclPin), .sdaRel,
        .latch(latchPin));

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic print_verdict();
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    task automatic drain();
        for (int i = 0; i < 60 && expQ.size() > 0; i++)
            @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
        chk("pending writes", 16'h0000, 16'(expQ.size()));
    endtask : drain
    task automatic tw(input logic [7:0] a, input logic [15:0] w, input logic good);
        logic [2:0] q;
        if (good)
            expQ.push_back(w);
        ccp_host_model_i.start();
        ccp_host_model_i.sendByte(a, q[2]);
        ccp_host_model_i.sendByte(w[15:8], q[1]);
        ccp_host_model_i.sendByte(w[7:0], q[0]);
        ccp_host_model_i.stop();
        chk("ack bits", {13'h0000, {3{!good}}}, {13'h0000, q});
        drain();
    endtask : tw
    task automatic sp(input logic [15:0] w, input int n);
        if (n == 16)
            expQ.push_back(w);
        ccp_host_model_i.spi(w, n);
        drain();
    endtask : sp

    // One-cycle strobe seen at the falling edge; a stray one counts too
    always @(negedge ref_clk) begin
        if (regWrStb === 1'b1) begin
            if (expQ.size() == 0)
                chk("stray write", 16'h0000, 16'h0001);
            else
                chk("command", expQ.pop_front(), {regWrAddr, regWrData});
        end
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        void'($urandom(3637));
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("enable", 16'h0000, 16'(audioPortEn));
        chk("pull-down", 16'h0001, 16'(audioPortPullDown));
        tw(8'h34, ACT1, 1'b1);
        chk("pull-down", 16'h0000, 16'(audioPortPullDown));
        ccp_host_model_i.latch = 1'b1;
        tw(8'h34, ACT0, 1'b0);
        tw(8'h37, ACT0, 1'b0);
        chk("enable", 16'h0001, 16'(audioPortEn));
        tw(8'h36, ACT0, 1'b1);
        ccp_host_model_i.start();
        ccp_host_model_i.sendByte(8'h36, k);
        ccp_host_model_i.sendByte(ACT1[15:8], k);
        ccp_host_model_i.stop();
        drain();
        chk("enable", 16'h0000, 16'(audioPortEn));
        selPin = 1'b1;
        ccp_host_model_i.latch = 1'b0;
        sp(ACT1, 15);
        chk("enable", 16'h0000, 16'(audioPortEn));
        foreach (rc[j]) begin
            sp({ccp_pkg::ADDR_SAMPLING, 3'h0, rc[j], 1'b1}, 16);
            chk("filter", 16'(ftX[j]), 16'(filterType));
            chk("adc divider", 16'(adcX[j]), adcDivider);
            chk("dac divider", 16'(dacX[j]), dacDivider);
            chk("supported", 16'h0001, 16'(rateSupported));
        end
        do
            r = 5'($urandom());
        while (r inside {0, 2, 4, 6, 12, 14, 17, 19, 21, 23, 31});
        sp({ccp_pkg::ADDR_SAMPLING, 3'h0, r, 1'b1}, 16);
        chk("supported", 16'h0000, 16'(rateSupported));
        sp(ACT1, 16);
        clkEn = 1'b0;
        ccp_host_model_i.spi(ACT0, 16);
        clkEn = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("frozen enable", 16'h0001, 16'(audioPortEn));
        tw(8'h36, ACT0, 1'b0);
        chk("enable", 16'h0001, 16'(audioPortEn));
        print_verdict();
    end
endmodule : codec_control_port_test
`default_nettype wire
